// *** logic/pfcr_pkg.sv ***
// constants and types for the link temperature fan control register slice
// ============================================================
// Operation
// - found flag reads one when processor detected
// - retry suppress bit stops retry after bad completion
// - rate field selects 1, 2, 5, 10 polls/sec
// - write permit bit gates processor write commands
// - three duty ceilings, reset full scale
// - above start threshold run minimum then ramp
// - span field sets ramp width, default 32 degrees
// - reading above critical limit forces full duty
// - limit 0x80 disables fail-safe, resets zero
// - full duty held until below limit minus hysteresis
`default_nettype none
package pfcr_pkg;
    localparam logic [7:0] PFCR_ADDR_CFG3 = 8'h37;
    localparam logic [7:0] PFCR_ADDR_CEIL1 = 8'h38;
    localparam logic [7:0] PFCR_ADDR_CEIL2 = 8'h39;
    localparam logic [7:0] PFCR_ADDR_CEIL3 = 8'h3a;
    localparam logic [7:0] PFCR_ADDR_TSTART = 8'h3b;
    localparam logic [7:0] PFCR_ADDR_SPAN = 8'h3c;
    localparam logic [7:0] PFCR_ADDR_CRIT = 8'h3d;
    localparam logic [7:0] PFCR_RST_CFG3 = 8'h32;
    localparam logic [7:0] PFCR_RST_CEIL = 8'hff;
    localparam logic [7:0] PFCR_RST_TSTART = 8'hd6;
    localparam logic [7:0] PFCR_RST_SPAN = 8'hc0;
    localparam logic [7:0] PFCR_RST_CRIT = 8'h00;
    localparam logic [7:0] PFCR_CRIT_OFF = 8'h80;
    localparam logic [7:0] PFCR_FULL_DUTY = 8'hff;
    // writable masks; reserved bits read zero
    localparam logic [7:0] PFCR_MASK_CFG3 = 8'hb3;
    localparam logic [7:0] PFCR_MASK_SPAN = 8'hf0;
    localparam int PFCR_BIT_FOUND = 0;
    localparam int PFCR_BIT_RETRY = 1;
    localparam int PFCR_BIT_RATE = 4;
    localparam int PFCR_BIT_PERMIT = 7;
    localparam int PFCR_BIT_SPAN = 4;
    localparam int PFCR_NUM_FANS = 3;
    localparam int PFCR_CLK_HZ = 100_000_000;
    localparam int PFCR_POLL_1 = PFCR_CLK_HZ / 1;
    localparam int PFCR_POLL_2 = PFCR_CLK_HZ / 2;
    localparam int PFCR_POLL_5 = PFCR_CLK_HZ / 5;
    localparam int PFCR_POLL_10 = PFCR_CLK_HZ / 10;
    // span in quarter degrees, one per code 0000..1111
    localparam logic [8:0] PFCR_SPAN_Q [16] = '{
        9'd8, 9'd10, 9'd13, 9'd16, 9'd20, 9'd27, 9'd32, 9'd40,
        9'd53, 9'd64, 9'd80, 9'd107, 9'd128, 9'd160, 9'd213, 9'd320};

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pfcr_bus_s;

    typedef struct packed {
        logic valid;
        logic [7:0] temp;
    } pfcr_reading_s;

    typedef enum logic [1:0] {
        PFCR_ST_OFF = 2'b00,
        PFCR_ST_RAMP = 2'b01,
        PFCR_ST_FORCED = 2'b10
    } pfcr_state_e;
endpackage
`default_nettype wire

// *** logic/pfcr_duty_calc.sv ***
// per-fan automatic duty computation along the ramp
`default_nettype none
module pfcr_duty_calc
    import pfcr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // operands
    input wire logic signed [7:0] temp_i,
    input wire logic signed [7:0] start_i,
    input wire logic [3:0] span_code_i,
    input wire logic [7:0] floor_i,
    input wire logic [7:0] ceil_i,
    // result
    output logic [7:0] duty_o
);
    logic signed [9:0] excess;
    logic [19:0] step;
    logic [8:0] span_q;
    logic [8:0] sum;
    logic [7:0] duty_d;

    always_comb begin
        excess = 10'(temp_i) - 10'(start_i);
        span_q = PFCR_SPAN_Q[span_code_i];
        // quarter-degree span keeps fractional spans; step is divided by the table entry
        step = (excess > 0) ?
            20'((20'(excess) * 20'd4 * 20'(8'(ceil_i - floor_i)))
                / 20'(span_q)) : 20'd0;
        sum = 9'(floor_i) + ((step > 20'd255) ? 9'd255 : 9'(step));
        if (excess <= 0) begin
            duty_d = 8'h00;
        end else if (sum >= 9'(ceil_i) || ceil_i < floor_i) begin
            duty_d = ceil_i;
        end else begin
            duty_d = sum[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            duty_o <= 8'h00;
        end else begin
            duty_o <= duty_d;
        end
    end
endmodule
`default_nettype wire

// *** logic/pfcr_regs.sv ***
// register slice and fail-safe for link temperature fan control
`default_nettype none
module pfcr_regs
    import pfcr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register access from the two-wire slave
    input wire pfcr_bus_s bus_i,
    output logic [7:0] rdata_o,
    // link engine status and readings
    input wire logic proc_found_i,
    input wire pfcr_reading_s reading_i,
    input wire logic auto_mode_i,
    // configuration held elsewhere
    input wire logic [7:0] hysteresis_i,
    input wire logic [7:0] min_duty_floor_i,
    // link engine controls
    output logic retry_suppress_o,
    output logic cpu_write_permit_o,
    output logic poll_tick_o,
    // fan drive
    output logic [23:0] fan_duty_o,
    output logic forced_full_o
);
    // ============================================================
    // registers
    logic [7:0] cfg3_q;
    logic [7:0] ceil_q [PFCR_NUM_FANS];
    logic [7:0] tstart_q;
    logic [7:0] span_q;
    logic [7:0] crit_q;
    logic found_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return bus_i.wr && (a == b);
    endfunction

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg3_q <= PFCR_RST_CFG3 & PFCR_MASK_CFG3;
            tstart_q <= PFCR_RST_TSTART;
            span_q <= PFCR_RST_SPAN;
            crit_q <= PFCR_RST_CRIT;
        end else begin
            if (hit(bus_i.addr, PFCR_ADDR_CFG3)) begin
                cfg3_q <= bus_i.wdata & PFCR_MASK_CFG3;
            end
            // out-of-range threshold is left to software, not clamped
            if (hit(bus_i.addr, PFCR_ADDR_TSTART)) begin
                tstart_q <= bus_i.wdata;
            end
            if (hit(bus_i.addr, PFCR_ADDR_SPAN)) begin
                span_q <= bus_i.wdata & PFCR_MASK_SPAN;
            end
            if (hit(bus_i.addr, PFCR_ADDR_CRIT)) begin
                crit_q <= bus_i.wdata;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        for (int i = 0; i < PFCR_NUM_FANS; i++) begin
            if (reset_i) begin
                ceil_q[i] <= PFCR_RST_CEIL;
            end else if (hit(bus_i.addr, 8'(PFCR_ADDR_CEIL1 + 8'(i)))) begin
                ceil_q[i] <= bus_i.wdata;
            end
        end
    end

    // detection wins over a software write in the same cycle
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            found_q <= PFCR_RST_CFG3[PFCR_BIT_FOUND];
        end else if (proc_found_i) begin
            found_q <= 1'b1;
        end else if (hit(bus_i.addr, PFCR_ADDR_CFG3)) begin
            found_q <= bus_i.wdata[PFCR_BIT_FOUND];
        end
    end

    // ============================================================
    // read mux
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                PFCR_ADDR_CFG3: rdata_o <= {cfg3_q[7:1], found_q};
                PFCR_ADDR_CEIL1: rdata_o <= ceil_q[0];
                PFCR_ADDR_CEIL2: rdata_o <= ceil_q[1];
                PFCR_ADDR_CEIL3: rdata_o <= ceil_q[2];
                PFCR_ADDR_TSTART: rdata_o <= tstart_q;
                PFCR_ADDR_SPAN: rdata_o <= span_q;
                PFCR_ADDR_CRIT: rdata_o <= crit_q;
                default: rdata_o <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            retry_suppress_o <= 1'b0;
            cpu_write_permit_o <= 1'b0;
        end else begin
            retry_suppress_o <= cfg3_q[PFCR_BIT_RETRY];
            cpu_write_permit_o <= cfg3_q[PFCR_BIT_PERMIT];
        end
    end

    // ============================================================
    // poll rate
    logic [26:0] poll_cnt_q;
    logic [26:0] poll_period;

    always_comb begin
        case (cfg3_q[PFCR_BIT_RATE +: 2])
            2'b00: poll_period = 27'(PFCR_POLL_1);
            2'b01: poll_period = 27'(PFCR_POLL_2);
            2'b10: poll_period = 27'(PFCR_POLL_5);
            default: poll_period = 27'(PFCR_POLL_10);
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            poll_cnt_q <= 27'h0;
            poll_tick_o <= 1'b0;
        end else if (poll_cnt_q >= poll_period - 27'h1) begin
            poll_cnt_q <= 27'h0;
            poll_tick_o <= 1'b1;
        end else begin
            poll_cnt_q <= poll_cnt_q + 27'h1;
            poll_tick_o <= 1'b0;
        end
    end

    // ============================================================
    // critical fail-safe, signed readings
    pfcr_state_e state_q;
    logic signed [9:0] release_at;
    logic signed [7:0] last_temp_q;

    // ten bits: a low limit minus a large hysteresis must not wrap positive
    assign release_at = 10'(signed'(crit_q))
        - 10'(signed'({2'b00, hysteresis_i}));

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_q <= PFCR_ST_OFF;
            last_temp_q <= signed'(PFCR_RST_TSTART);
        end else begin
            if (reading_i.valid) begin
                last_temp_q <= signed'(reading_i.temp);
            end
            if (crit_q == PFCR_CRIT_OFF) begin
                state_q <= PFCR_ST_OFF;
            end else if (reading_i.valid) begin
                case (state_q)
                    PFCR_ST_FORCED: begin
                        if (10'(signed'(reading_i.temp)) < release_at) begin
                            state_q <= PFCR_ST_RAMP;
                        end
                    end
                    default: begin
                        if (signed'(reading_i.temp) > signed'(crit_q)) begin
                            state_q <= PFCR_ST_FORCED;
                        end else begin
                            state_q <= PFCR_ST_RAMP;
                        end
                    end
                endcase
            end
        end
    end

    // ============================================================
    // duty per fan
    logic [7:0] auto_duty [PFCR_NUM_FANS];

    for (genvar g = 0; g < PFCR_NUM_FANS; g++) begin : g_fan
        pfcr_duty_calc u_calc (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .temp_i(last_temp_q),
            .start_i(signed'(tstart_q)),
            .span_code_i(span_q[PFCR_BIT_SPAN +: 4]),
            .floor_i(min_duty_floor_i),
            .ceil_i(ceil_q[g]),
            .duty_o(auto_duty[g])
        );
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fan_duty_o <= {PFCR_NUM_FANS{PFCR_FULL_DUTY}};
            forced_full_o <= 1'b0;
        end else begin
            forced_full_o <= (state_q == PFCR_ST_FORCED);
            for (int i = 0; i < PFCR_NUM_FANS; i++) begin
                if (state_q == PFCR_ST_FORCED) begin
                    fan_duty_o[i*8 +: 8] <= PFCR_FULL_DUTY;
                end else if (auto_mode_i) begin
                    fan_duty_o[i*8 +: 8] <= auto_duty[i];
                end else begin
                    fan_duty_o[i*8 +: 8] <= ceil_q[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/pfcr_cpu_model.sv ***
// processor side of the temperature link
`default_nettype none
module pfcr_cpu_model
    import pfcr_pkg::*;
(
    // clock
    input wire logic clk_i,
    // link engine view
    output logic found_o,
    output pfcr_reading_s reading_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============
    // answers
    initial begin
        found_o = 1'b0;
        reading_o = '0;
    end
    task automatic detect();
        @(posedge clk_i);
        found_o <= 1'b1;
        @(posedge clk_i);
        found_o <= 1'b0;
    endtask
    // stale value is inverted so a late sample cannot pass
    task automatic send(input logic [7:0] t);
        @(posedge clk_i);
        reading_o <= '{valid: 1'b1, temp: t};
        @(posedge clk_i);
        reading_o <= '{valid: 1'b0, temp: ~t};
    endtask
endmodule
`default_nettype wire

// *** dv/pfcr_chk.sv ***
// assertions on the link fan control register slice
`default_nettype none
module pfcr_chk
    import pfcr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // watched ports
    input wire pfcr_bus_s bus_i,
    input wire logic [7:0] rdata_o,
    input wire pfcr_reading_s reading_i,
    input wire logic [7:0] hysteresis_i,
    input wire logic retry_suppress_o,
    input wire logic cpu_write_permit_o,
    input wire logic [23:0] fan_duty_o,
    input wire logic forced_full_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============
    // limit shadow
    logic [7:0] crit_q;
    logic hot;
    logic cool;
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            crit_q <= 8'h00;
        end else if (bus_i.wr && bus_i.addr == PFCR_ADDR_CRIT) begin
            crit_q <= bus_i.wdata;
        end
    end
    assign hot = reading_i.valid && crit_q != PFCR_CRIT_OFF
        && $signed(reading_i.temp) > $signed(crit_q);
    // ten bits so limit minus hysteresis cannot wrap
    assign cool = reading_i.valid && $signed({{2{reading_i.temp[7]}},
        reading_i.temp}) < $signed({{2{crit_q[7]}}, crit_q})
        - $signed({2'b00, hysteresis_i});
    // ============
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_cfg_wr;
        bus_i.wr && bus_i.addr == PFCR_ADDR_CFG3;
    endsequence
    sequence s_full;
        ##2 forced_full_o && fan_duty_o == {3{PFCR_FULL_DUTY}};
    endsequence
    property p_retry;
        s_cfg_wr |-> ##2 retry_suppress_o == $past(bus_i.wdata[1], 2);
    endproperty
    property p_permit;
        s_cfg_wr ##2 1'b1 |-> cpu_write_permit_o == $past(bus_i.wdata[7], 2);
    endproperty
    property p_force;
        hot |-> s_full;
    endproperty
    property p_full;
        forced_full_o |-> fan_duty_o == {3{PFCR_FULL_DUTY}};
    endproperty
    property p_hold;
        // a disable written one cycle back may drop the force legally
        forced_full_o && !cool && !$past(cool)
            && $past(crit_q) != PFCR_CRIT_OFF |=> forced_full_o;
    endproperty
    property p_release;
        cool && forced_full_o |-> ##2 !forced_full_o;
    endproperty
    property p_off;
        reading_i.valid && crit_q == PFCR_CRIT_OFF
            && $past(crit_q) == PFCR_CRIT_OFF |=> !forced_full_o [*2];
    endproperty
    property p_unmapped;
        bus_i.rd && (bus_i.addr < PFCR_ADDR_CFG3
            || bus_i.addr > PFCR_ADDR_CRIT) |=> rdata_o == 8'h00;
    endproperty
    property p_reserved;
        bus_i.rd && bus_i.addr == PFCR_ADDR_SPAN |=> rdata_o[3:0] == 4'h0;
    endproperty
    a_retry: assert property (p_retry)
        else $error("retry suppress out of step");
    a_permit: assert property (p_permit)
        else $error("write permit out of step");
    a_force: assert property (p_force)
        else $error("no forced full duty");
    a_full: assert property (p_full)
        else $error("forced but duty not full");
    a_hold: assert property (p_hold)
        else $error("forced duty dropped early");
    a_release: assert property (p_release)
        else $error("forced duty not released");
    a_off: assert property (p_off)
        else $error("fail safe active while disabled");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    a_reserved: assert property (p_reserved)
        else $error("span reserved bits not zero");
endmodule
bind pfcr_regs pfcr_chk i_chk (.clk_i(clk_i), .reset_i(reset_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .reading_i(reading_i),
    .hysteresis_i(hysteresis_i), .retry_suppress_o(retry_suppress_o),
    .cpu_write_permit_o(cpu_write_permit_o), .fan_duty_o(fan_duty_o),
    .forced_full_o(forced_full_o));
`default_nettype wire

// *** dv/tb.sv ***
// bench for the link fan control register slice
`default_nettype none
module tb
    import pfcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected %0t got %h exp %h", $time, a, e); end end
    // ============
    // signals
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic auto_q = 1'b0;
    logic [7:0] hyst_q = 8'h05;
    pfcr_bus_s bus_q = '0;
    logic [7:0] rdata;
    logic found, retry, permit, forced, tick;
    logic [23:0] duty;
    pfcr_reading_s reading;
    int n_fail = 0;
    int num_checks = 0;
    int cyc = 0;
    int n_tick = 0;
    logic [7:0] rst_val [7] = '{8'h32, 8'hff, 8'hff, 8'hff, 8'hd6,
        8'hc0, 8'h00};
    always #5 clk_i = ~clk_i;
    pfcr_cpu_model i_cpu (.clk_i(clk_i), .found_o(found),
        .reading_o(reading));
    pfcr_regs i_dut (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_q),
        .rdata_o(rdata), .proc_found_i(found), .reading_i(reading),
        .auto_mode_i(auto_q), .hysteresis_i(hyst_q),
        .min_duty_floor_i(8'h40), .retry_suppress_o(retry),
        .cpu_write_permit_o(permit), .poll_tick_o(tick),
        .fan_duty_o(duty), .forced_full_o(forced));
    // ============
    // access tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        bus_q <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        bus_q <= '0;
        @(negedge clk_i);
        `CHK(rdata, e)
    endtask
    // duty has a compute stage behind the limit logic
    task automatic temp(input logic [7:0] t);
        i_cpu.send(t);
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (tick) begin
            n_tick++;
        end
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    // ============
    // tests
    initial begin
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            rd(8'h37 + 8'(i), rst_val[i]);
        end
        rd(8'h3e, 8'h00);
        wr(8'h37, 8'hff);
        rd(8'h37, 8'hb3);
        `CHK({permit, retry}, 2'b11)
        wr(8'h37, 8'h00);
        rd(8'h37, 8'h00);
        `CHK({permit, retry}, 2'b00)
        for (int r = 0; r < 4; r++) begin
            wr(8'h37, 8'(r << 4));
            rd(8'h37, 8'(r << 4));
        end
        i_cpu.detect();
        rd(8'h37, 8'h31);
        wr(8'h3c, 8'hff);
        rd(8'h3c, 8'hf0);
        for (int i = 0; i < 3; i++) begin
            wr(8'h38 + 8'(i), 8'hf0 + 8'(i));
            rd(8'h38 + 8'(i), 8'hf0 + 8'(i));
        end
        `CHK(duty, 24'hf2f1f0)
        wr(8'h3d, 8'h80);
        wr(8'h3b, 8'h20);
        @(posedge clk_i);
        auto_q <= 1'b1;
        temp(8'h10);
        `CHK(duty, 24'h000000)
        temp(8'h21);
        `CHK(duty[7:0] >= 8'h40 && duty[7:0] <= 8'h43, 1'b1)
        temp(8'h70);
        `CHK(duty, 24'hf2f1f0)
        wr(8'h3d, 8'h50);
        temp(8'h51);
        `CHK({forced, duty}, {1'b1, 24'hffffff})
        temp(8'h4c);
        `CHK(forced, 1'b1)
        temp(8'h4a);
        `CHK(forced, 1'b0)
        @(posedge clk_i);
        hyst_q <= 8'h10;
        temp(8'h51);
        temp(8'h42);
        `CHK(forced, 1'b1)
        temp(8'h3f);
        wr(8'h3d, 8'h80);
        temp(8'h7f);
        `CHK(forced, 1'b0)
        // even the fastest poll period outlasts the whole run
        `CHK(n_tick, 0)
        give_verdict();
    end
endmodule
`default_nettype wire
